// File: rtl/mpc_chain.v
// Measurement post-processing chain: offset removal, smoothing, scaling.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "mpc_defines.vh"

// Summary of operation
// RULE1: Enabled offset stage outputs measurement minus constant.
// RULE2: Enabling offset captures next measurement as constant.
// RULE3: Overload samples bypass subtraction, never captured.
// RULE4: Offset constant limited to +-9999999 mantissa.
// RULE5: Second offset key disables stage, indicator off.
// RULE6: Offset off on key, function change, reset.
// RULE7: Smoother outputs mean of last N samples.
// RULE8: Before N samples, mean of samples so far.
// RULE9: Smoother indicator blinks until N reached.
// RULE10: Window length N programmable two to hundred.
// RULE11: Smoother restarts on power, N, offset, burst.
// RULE12: Overload samples never enter smoother history.
// RULE13: Smoother off on key, function change, reset.
// RULE14: Scaling outputs (M minus B) over A times C.
// RULE15: Constants mantissa plus exponent; A never zero.
// RULE16: Scaled result above limit flags overflow.
// RULE17: Autorange sees value before post-processing.
// RULE18: Scaling key toggles stage and its indicator.
// RULE19: Scaling off on key, function change, reset.
// RULE20: Active stages format prefix from result magnitude.
// RULE21: Capture key loads measurement into edited constant; the code ignores the key while the offset slot is selected.
// RULE22: Exponent is prefix none,k,M,n,u,m.
// RULE23: Stages run offset, smoothing, scaling, overload follows.
module mpc_chain #(
  parameter VW        = 96,
  parameter NMAX      = 100,
  parameter BLINK_CYC = `MPC_BLINK_MS * (`MPC_CLK_HZ / 1000)
) (
  input  wire          clk,
  input  wire          resetn,
  input  wire [7:0]    reg_addr,
  input  wire [31:0]   reg_wdata,
  input  wire          reg_we,
  input  wire          reg_re,
  output reg  [31:0]   reg_rdata,
  input  wire          meas_valid,
  input  wire [VW-1:0] meas_value,
  input  wire          meas_overload,
  output reg           meas_ready,
  input  wire [2:0]    range_prefix,
  input  wire          null_key,
  input  wire          smooth_key,
  input  wire          scale_key,
  input  wire          capture_measurement_key,
  input  wire          function_change,
  input  wire          reset_cmd,
  input  wire          burst_start,
  output reg           res_valid,
  output reg  [VW-1:0] res_value,
  output reg           overload_flag,
  output reg           scaling_overflow_flag,
  output reg  [2:0]    res_prefix,
  output reg  [VW-1:0] autorange_value,
  output reg           autorange_overload,
  output reg           null_indicator,
  output reg           smoother_indicator,
  output reg           scaling_indicator
);

  localparam DW = 2 * VW + 2;
  localparam SW = VW + 7;
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_SMDIV = 3'h1;
  localparam [2:0] S_SCL   = 3'h2;
  localparam [2:0] S_SCDIV = 3'h3;
  localparam [2:0] S_OUT   = 3'h4;

  // ************************************************************
  // Arithmetic helpers
  // ************************************************************
  // Internal values are signed integers in units of 1e-14.
  function [VW-1:0] pow10;
    input integer k;
    integer i;
    begin
      pow10 = {{(VW-1){1'b0}}, 1'b1};
      for (i = 0; i < 24; i = i + 1) begin
        if (i < k) begin
          pow10 = pow10 * {{(VW-4){1'b0}}, 4'hA};
        end
      end
    end
  endfunction

  function [31:0] clamp_mant;
    input [31:0] w;
    begin
      if ($signed(w) > $signed(`MPC_MANT_MAX)) begin
        clamp_mant = `MPC_MANT_MAX;
      end else if ($signed(w) < -$signed(`MPC_MANT_MAX)) begin
        clamp_mant = -`MPC_MANT_MAX;
      end else begin
        clamp_mant = w;
      end
    end
  endfunction

  // Mantissa scaled by prefix and decimal point.
  function [VW-1:0] conv;
    input [31:0] mant;
    input [7:0]  ex;
    integer k;
    integer dp;
    begin
      dp = (ex[6:4] > `MPC_DP_MAX) ? `MPC_DP_MAX : ex[6:4];
      case (ex[2:0])
        `MPC_PFX_KILO:  k = 3;
        `MPC_PFX_MEGA:  k = 6;
        `MPC_PFX_NANO:  k = -9;
        `MPC_PFX_MICRO: k = -6;
        `MPC_PFX_MILLI: k = -3;
        default:        k = 0;
      endcase
      conv = {{(VW-32){mant[31]}}, mant} * pow10(`MPC_UNIT_EXP + k - dp);
    end
  endfunction

  function [DW-1:0] abs_dw;
    input [DW-1:0] x;
    begin
      abs_dw = x[DW-1] ? -x : x;
    end
  endfunction

  // Display prefix chosen from result magnitude.
  function [2:0] mag_prefix;
    input [VW-1:0] m;
    begin
      if (m >= pow10(20)) begin
        mag_prefix = `MPC_PFX_MEGA;
      end else if (m >= pow10(17)) begin
        mag_prefix = `MPC_PFX_KILO;
      end else if (m >= pow10(14)) begin
        mag_prefix = `MPC_PFX_NONE;
      end else if (m >= pow10(11)) begin
        mag_prefix = `MPC_PFX_MILLI;
      end else if (m >= pow10(8)) begin
        mag_prefix = `MPC_PFX_MICRO;
      end else begin
        mag_prefix = `MPC_PFX_NANO;
      end
    end
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  reg [2:0]    state_q;
  reg          null_en_q, null_arm_q, sm_en_q, sc_en_q;
  reg [6:0]    n_q, fill_q, wp_q;
  reg [SW-1:0] sum_q;
  reg [VW-1:0] hist_q [0:NMAX-1];
  reg [31:0]   mant_q [0:3];
  reg [7:0]    exp_q  [0:3];
  reg [VW-1:0] cval_q [0:3];
  reg [1:0]    edit_q;
  reg [VW-1:0] last_raw_q, cur_q;
  reg          ovl_q, sovf_q, last_sovf_q;
  reg [2:0]    range_q;
  reg          div_run_q, div_neg_q;
  reg [7:0]    div_cnt_q;
  reg [VW:0]   div_rem_q;
  reg [DW-1:0] div_quo_q;
  reg [VW-1:0] div_den_q;
  reg [31:0]   blink_cnt_q;
  reg          blink_q;
  integer      i;

  wire acc    = meas_valid & meas_ready;
  wire any_en = null_en_q | sm_en_q | sc_en_q;
  wire clr_all = function_change | reset_cmd;
  // Slot from word index: 3/4 null, 5/6 A, 7/8 B, 9/10 C.
  wire [3:0] kidx = reg_addr[5:2] - 4'h3;
  wire [1:0] ka   = kidx[2:1];

  wire cst_hit = reg_addr >= `MPC_REG_NULL_M && reg_addr <= `MPC_REG_C_E &&
                 reg_addr[1:0] == 2'h0;
  wire is_mant = reg_addr[2];

  // Offset stage changes also restart the smoother.
  wire null_toggle = null_key | (clr_all & null_en_q);
  wire n_wr = reg_we && reg_addr == `MPC_REG_SMCOUNT &&
              reg_wdata[6:0] >= `MPC_SMN_MIN &&
              reg_wdata[6:0] <= `MPC_SMN_MAX && reg_wdata[31:7] == 25'h0;
  // RULE11: restart conditions
  wire flush = null_toggle | burst_start | smooth_key | clr_all |
               (n_wr && reg_wdata[6:0] != n_q);

  // RULE1: subtract offset
  // RULE2: captured sample removes itself
  wire [VW-1:0] v1 = !null_en_q ? meas_value :
                     null_arm_q ? {VW{1'b0}} : meas_value - cval_q[0];

  // RULE7: sliding sum update
  wire          full   = fill_q == n_q;
  wire [VW-1:0] oldest = hist_q[wp_q];
  wire [SW-1:0] sum_nx = sum_q + {{(SW-VW){v1[VW-1]}}, v1} -
                         (full ? {{(SW-VW){oldest[VW-1]}}, oldest} :
                                 {SW{1'b0}});
  // RULE8: divide by samples so far
  wire [6:0]    fill_nx = full ? fill_q : fill_q + 7'h01;
  wire [DW-1:0] sm_div  = {{(DW-SW){sum_nx[SW-1]}}, sum_nx};

  // RULE14: (M - B) * C, then over A
  wire signed [VW:0]   sdiff = $signed({cur_q[VW-1], cur_q}) -
                               $signed({cval_q[2][VW-1], cval_q[2]});
  wire signed [DW-1:0] sprod = sdiff * $signed(cval_q[3]);

  // Restoring divider step, one quotient bit per cycle.
  wire [VW:0] d_sh  = {div_rem_q[VW-1:0], div_quo_q[DW-1]};
  wire        d_ge  = d_sh >= {1'b0, div_den_q};
  wire [VW:0] d_rem = d_ge ? d_sh - {1'b0, div_den_q} : d_sh;
  wire        q_big = |div_quo_q[DW-1:VW-1];
  wire [VW-1:0] q_s = div_neg_q ? -div_quo_q[VW-1:0] : div_quo_q[VW-1:0];
  wire [VW-1:0] lim = `MPC_LIM_MANT * pow10(`MPC_LIM_EXP);
  wire [VW-1:0] cur_abs = cur_q[VW-1] ? -cur_q : cur_q;

  // ************************************************************
  // History memory, unreset: the fill count guards it.
  // ************************************************************
  always @(posedge clk) begin
    // RULE12: overload never stored
    if (state_q == S_IDLE && acc && !meas_overload && sm_en_q && !flush) begin
      hist_q[wp_q] <= v1;
    end
  end

  // ************************************************************
  // Control, datapath and register file
  // ************************************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q     <= S_IDLE;
      null_en_q   <= 1'b0;
      null_arm_q  <= 1'b0;
      sm_en_q     <= 1'b0;
      sc_en_q     <= 1'b0;
      n_q         <= `MPC_SMN_RST;
      fill_q      <= 7'h00;
      wp_q        <= 7'h00;
      sum_q       <= {SW{1'b0}};
      edit_q      <= 2'h0;
      last_raw_q  <= {VW{1'b0}};
      cur_q       <= {VW{1'b0}};
      ovl_q       <= 1'b0;
      sovf_q      <= 1'b0;
      last_sovf_q <= 1'b0;
      range_q     <= 3'h0;
      div_run_q   <= 1'b0;
      div_neg_q   <= 1'b0;
      div_cnt_q   <= 8'h00;
      div_rem_q   <= {(VW+1){1'b0}};
      div_quo_q   <= {DW{1'b0}};
      div_den_q   <= {VW{1'b0}};
      for (i = 0; i < 4; i = i + 1) begin
        mant_q[i] <= 32'h0;
        exp_q[i]  <= 8'h00;
        cval_q[i] <= {VW{1'b0}};
      end
      cval_q[1]   <= {{(VW-1){1'b0}}, 1'b1};
      meas_ready  <= 1'b1;
      reg_rdata   <= 32'h0;
      res_valid   <= 1'b0;
      res_value   <= {VW{1'b0}};
      overload_flag         <= 1'b0;
      scaling_overflow_flag <= 1'b0;
      res_prefix            <= 3'h0;
      autorange_value       <= {VW{1'b0}};
      autorange_overload    <= 1'b0;
      null_indicator        <= 1'b0;
      smoother_indicator    <= 1'b0;
      scaling_indicator     <= 1'b0;
      blink_cnt_q <= 32'h0;
      blink_q     <= 1'b0;
    end else begin
      res_valid <= 1'b0;
      // Half-period blink timer for the smoother lamp.
      if (blink_cnt_q >= BLINK_CYC - 1) begin
        blink_cnt_q <= 32'h0;
        blink_q     <= ~blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 32'h1;
      end
      // RULE5: second key press disables
      // RULE6: offset stage disable events
      if (clr_all) begin
        null_en_q  <= 1'b0;
        null_arm_q <= 1'b0;
      end else if (null_key) begin
        null_en_q  <= ~null_en_q;
        null_arm_q <= ~null_en_q;
      end
      // RULE13: smoother disable events
      if (clr_all) begin
        sm_en_q <= 1'b0;
      end else if (smooth_key) begin
        sm_en_q <= ~sm_en_q;
      end
      // RULE18: scaling toggle
      // RULE19: scaling disable events
      if (clr_all) begin
        sc_en_q <= 1'b0;
      end else if (scale_key) begin
        sc_en_q <= ~sc_en_q;
      end
      null_indicator    <= null_en_q;
      scaling_indicator <= sc_en_q;
      // RULE9: blink until window filled
      smoother_indicator <= sm_en_q & (full | blink_q);

      // Divider runs on its own once started.
      if (div_run_q) begin
        div_rem_q <= d_rem;
        div_quo_q <= {div_quo_q[DW-2:0], d_ge};
        div_cnt_q <= div_cnt_q + 8'h01;
        if (div_cnt_q == DW - 1) begin
          div_run_q <= 1'b0;
        end
      end

      // RULE23: offset, smoothing, scaling in order
      case (state_q)
        S_IDLE: begin
          if (acc) begin
            meas_ready  <= 1'b0;
            last_raw_q  <= meas_value;
            range_q     <= range_prefix;
            ovl_q       <= meas_overload;
            sovf_q      <= 1'b0;
            // RULE17: autorange sees raw value
            autorange_value    <= meas_value;
            autorange_overload <= meas_overload;
            if (meas_overload) begin
              // RULE3: overload bypasses offset stage
              cur_q   <= meas_value;
              state_q <= S_OUT;
            end else begin
              cur_q <= v1;
              if (null_en_q && null_arm_q && !null_toggle) begin
                // RULE2: capture offset constant
                cval_q[0]  <= meas_value;
                null_arm_q <= 1'b0;
              end
              if (sm_en_q && !flush) begin
                sum_q     <= sum_nx;
                fill_q    <= fill_nx;
                wp_q      <= (wp_q == n_q - 7'h01) ? 7'h00 : wp_q + 7'h01;
                div_run_q <= 1'b1;
                div_cnt_q <= 8'h00;
                div_rem_q <= {(VW+1){1'b0}};
                div_quo_q <= abs_dw(sm_div);
                div_den_q <= {{(VW-7){1'b0}}, fill_nx};
                div_neg_q <= sm_div[DW-1];
                state_q   <= S_SMDIV;
              end else begin
                state_q <= S_SCL;
              end
            end
          end
        end
        S_SMDIV: begin
          if (!div_run_q) begin
            cur_q   <= q_s;
            state_q <= S_SCL;
          end
        end
        S_SCL: begin
          if (sc_en_q) begin
            div_run_q <= 1'b1;
            div_cnt_q <= 8'h00;
            div_rem_q <= {(VW+1){1'b0}};
            div_quo_q <= abs_dw(sprod);
            div_den_q <= cval_q[1][VW-1] ? -cval_q[1] : cval_q[1];
            div_neg_q <= sprod[DW-1] ^ cval_q[1][VW-1];
            state_q   <= S_SCDIV;
          end else begin
            state_q <= S_OUT;
          end
        end
        S_SCDIV: begin
          if (!div_run_q) begin
            cur_q <= q_s;
            // RULE16: scaled result above limit
            sovf_q  <= q_big | (div_quo_q[VW-1:0] > lim);
            state_q <= S_OUT;
          end
        end
        default: begin
          res_valid     <= 1'b1;
          res_value     <= sovf_q ? {VW{1'b0}} : cur_q;
          overload_flag <= ovl_q;
          scaling_overflow_flag <= sovf_q;
          last_sovf_q   <= sovf_q;
          // RULE20: prefix from result magnitude
          res_prefix <= (any_en && !ovl_q) ? mag_prefix(cur_abs) : range_q;
          meas_ready <= 1'b1;
          state_q    <= S_IDLE;
        end
      endcase

      // RULE11: flush history and restart
      if (flush) begin
        fill_q <= 7'h00;
        wp_q   <= 7'h00;
        sum_q  <= {SW{1'b0}};
      end
      // RULE10: window length two to hundred
      if (n_wr) begin
        n_q <= reg_wdata[6:0];
      end

      // Constant and edit-select writes.
      if (reg_we && reg_addr == `MPC_REG_EDITSEL) begin
        edit_q <= reg_wdata[1:0];
      end else if (reg_we && cst_hit && is_mant) begin
        // RULE4: mantissa range limit
        mant_q[ka] <= clamp_mant(reg_wdata);
      end else if (reg_we && cst_hit) begin
        // RULE22: prefix selects exponent
        exp_q[ka]  <= reg_wdata[7:0];
        cval_q[ka] <= conv(mant_q[ka], reg_wdata[7:0]);
        // RULE15: divisor forced nonzero
        if (ka == `MPC_K_A && conv(mant_q[ka], reg_wdata[7:0]) == 0) begin
          cval_q[ka] <= {{(VW-1){1'b0}}, 1'b1};
        end
      end else if (capture_measurement_key && edit_q != `MPC_K_NULL) begin
        // RULE21: load measurement into constant
        cval_q[edit_q] <= last_raw_q;
        mant_q[edit_q] <= last_raw_q[31:0];
        exp_q[edit_q]  <= {5'h00, `MPC_PFX_RAW};
        if (edit_q == `MPC_K_A && last_raw_q == 0) begin
          cval_q[edit_q] <= {{(VW-1){1'b0}}, 1'b1};
        end
      end

      // Read data stands one cycle only.
      reg_rdata <= 32'h0;
      if (reg_re) begin
        if (reg_addr == `MPC_REG_STATUS) begin
          reg_rdata <= {17'h0, fill_q, 2'h0, null_arm_q, last_sovf_q,
                        full, sc_en_q, sm_en_q, null_en_q};
        end else if (reg_addr == `MPC_REG_SMCOUNT) begin
          reg_rdata <= {25'h0, n_q};
        end else if (reg_addr == `MPC_REG_EDITSEL) begin
          reg_rdata <= {30'h0, edit_q};
        end else if (cst_hit && is_mant) begin
          reg_rdata <= mant_q[ka];
        end else if (cst_hit) begin
          reg_rdata <= {24'h0, exp_q[ka]};
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: common/mpc_defines.vh
// Register map, field layout, reset values and timing constants.
`ifndef MPC_DEFINES_VH
`define MPC_DEFINES_VH

// ************************************************************
// Register byte addresses
// ************************************************************
`define MPC_REG_STATUS   8'h00
`define MPC_REG_SMCOUNT  8'h04
`define MPC_REG_EDITSEL  8'h08
`define MPC_REG_NULL_M   8'h0C
`define MPC_REG_NULL_E   8'h10
`define MPC_REG_A_M      8'h14
`define MPC_REG_A_E      8'h18
`define MPC_REG_B_M      8'h1C
`define MPC_REG_B_E      8'h20
`define MPC_REG_C_M      8'h24
`define MPC_REG_C_E      8'h28

// ************************************************************
// Status bit positions
// ************************************************************
`define MPC_ST_NULL_EN   0
`define MPC_ST_SM_EN     1
`define MPC_ST_SC_EN     2
`define MPC_ST_SM_FULL   3
`define MPC_ST_SC_OVF    4
`define MPC_ST_NULL_ARM  5
`define MPC_ST_FILL_LSB  8

// ************************************************************
// Constant slots and exponent field
// ************************************************************
`define MPC_K_NULL       2'h0
`define MPC_K_A          2'h1
`define MPC_K_B          2'h2
`define MPC_K_C          2'h3
`define MPC_PFX_NONE     3'h0
`define MPC_PFX_KILO     3'h1
`define MPC_PFX_MEGA     3'h2
`define MPC_PFX_NANO     3'h3
`define MPC_PFX_MICRO    3'h4
`define MPC_PFX_MILLI    3'h5
`define MPC_PFX_RAW      3'h7
`define MPC_DP_MAX       3'h5
`define MPC_MANT_MAX     32'h0098967F
`define MPC_UNIT_EXP     14
`define MPC_LIM_MANT     999999
`define MPC_LIM_EXP      17

// ************************************************************
// Smoothing count and timing
// ************************************************************
`define MPC_SMN_MIN      7'h02
`define MPC_SMN_MAX      7'h64
`define MPC_SMN_RST      7'h0A
`define MPC_CLK_HZ       10000000
`define MPC_BLINK_MS     500

`endif

// File: testbench/mpc_src.sv
// Behavioural sample source at the chain's measurement input.
`timescale 1ns/1ps
`default_nettype none
module mpc_src (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        send,
  input  wire logic [3:0]  lag,
  input  wire logic [95:0] val,
  input  wire logic        ovl,
  input  wire logic        meas_ready,
  output var  logic        meas_valid,
  output var  logic [95:0] meas_value,
  output var  logic        meas_overload
);
  logic [3:0] wait_q;
  logic       pend_q;
  // A sample waits out its lag, then is offered until the chain takes it.
  // Taken lines show the inverse so stale data never looks valid.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {pend_q, wait_q, meas_valid} <= '0;
      {meas_value, meas_overload}  <= '0;
    end else if (send) begin
      {pend_q, wait_q} <= {1'b1, lag};
      meas_value       <= val;
      meas_overload    <= ovl;
    end else if (pend_q && wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end else if (pend_q) begin
      {pend_q, meas_valid} <= 2'b01;
    end else if (meas_valid && meas_ready) begin
      meas_valid    <= 1'b0;
      meas_value    <= ~meas_value;
      meas_overload <= ~meas_overload;
    end
  end
endmodule
`default_nettype wire

// File: testbench/mpc_chain_chk.sv
// Concurrent checks on the chain's ports.
`timescale 1ns/1ps
`default_nettype none
module mpc_chain_chk #(
  parameter VW = 96
) (
  input wire logic          clk,
  input wire logic          resetn,
  input wire logic          meas_valid,
  input wire logic [VW-1:0] meas_value,
  input wire logic          meas_overload,
  input wire logic          meas_ready,
  input wire logic          function_change,
  input wire logic          reset_cmd,
  input wire logic          scale_key,
  input wire logic          res_valid,
  input wire logic [VW-1:0] res_value,
  input wire logic          scaling_overflow_flag,
  input wire logic [VW-1:0] autorange_value,
  input wire logic          autorange_overload,
  input wire logic          null_indicator,
  input wire logic          smoother_indicator,
  input wire logic          scaling_indicator
);
  // ************************************************************
  // Handshake and results
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ready_drop_a: assert property (
    meas_valid && meas_ready |=> !meas_ready)
    else $error("ready high after take");
  answer_bound_a: assert property (
    meas_valid && meas_ready |-> ##[2:450] res_valid)
    else $error("no result");
  res_pulse_a: assert property (
    res_valid |=> !res_valid)
    else $error("result valid too long");
  ready_back_a: assert property (
    res_valid |-> meas_ready)
    else $error("ready low at result");
  raw_range_a: assert property (
    meas_valid && meas_ready |=> autorange_value == $past(meas_value)
      && autorange_overload == $past(meas_overload))
    else $error("autorange not raw");
  ovf_blank_a: assert property (
    res_valid && scaling_overflow_flag |-> res_value == {VW{1'b0}})
    else $error("value shown on overflow");
  stage_clear_a: assert property (
    function_change || reset_cmd |-> ##2
      !null_indicator && !smoother_indicator && !scaling_indicator)
    else $error("stage lit after clear");
  scale_toggle_a: assert property (
    scale_key && !function_change && !reset_cmd |-> ##2
      scaling_indicator != $past(scaling_indicator, 2))
    else $error("scaling lamp no toggle");
endmodule
bind mpc_chain mpc_chain_chk #(.VW(VW)) u_chk (.*);
`default_nettype wire

// File: testbench/measurement_postprocess_chain_tb_top.sv
// Self-checking bench for the measurement post-processing chain.
`timescale 1ns/1ps
`default_nettype none
`include "mpc_defines.vh"
module measurement_postprocess_chain_tb_top;
  localparam VW = 96;
  logic                 clk, resetn, reg_we, reg_re, send, ovl, res_valid;
  logic                 meas_valid, meas_overload, meas_ready, ovl_f, sovf;
  logic                 autorange_overload, null_ind, sm_ind, sc_ind;
  logic [7:0]           reg_addr;
  logic [31:0]          reg_wdata, reg_rdata, rd_d;
  logic [VW-1:0]        meas_value, val, res_value, ar_value;
  logic [2:0]           range_prefix, res_prefix;
  logic [3:0]           lag;
  logic [6:0]           kv;
  logic signed [VW-1:0] x1, x2, e, hist[$];
  int                   n_errors, compares, k, r;
  // ************************************************************
  // Clock, source and design
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  mpc_src i_src (.clk(clk), .resetn(resetn), .send(send), .lag(lag),
    .val(val), .ovl(ovl), .meas_ready(meas_ready), .meas_valid(meas_valid),
    .meas_value(meas_value), .meas_overload(meas_overload));
  // Short blink period makes the smoother lamp toggle every 4 cycles.
  mpc_chain #(.VW(VW), .NMAX(100), .BLINK_CYC(4)) i_dut (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .meas_valid(meas_valid),
    .meas_value(meas_value), .meas_overload(meas_overload),
    .meas_ready(meas_ready), .range_prefix(range_prefix),
    .null_key(kv[0]), .smooth_key(kv[1]), .scale_key(kv[2]),
    .capture_measurement_key(kv[3]), .function_change(kv[4]),
    .reset_cmd(kv[5]), .burst_start(kv[6]), .res_valid(res_valid),
    .res_value(res_value), .overload_flag(ovl_f),
    .scaling_overflow_flag(sovf), .res_prefix(res_prefix),
    .autorange_value(ar_value), .autorange_overload(autorange_overload),
    .null_indicator(null_ind), .smoother_indicator(sm_ind),
    .scaling_indicator(sc_ind));
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk_v(input string nm, input logic [VW-1:0] ex, got);
    compares++;
    if (got !== ex) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic chk_w(input string nm, input logic [31:0] ex, got);
    chk_v(nm, {64'h0, ex}, {64'h0, got});
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_we} <= {a, d, 1'b1};
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  // Read data stands only the cycle after the strobe.
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    {reg_addr, reg_re} <= {a, 1'b1};
    @(posedge clk);
    reg_re <= 1'b0;
    #1 rd_d = reg_rdata;
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    kv <= 7'h01 << b;
    @(posedge clk);
    kv <= 7'h00;
    repeat (3) @(posedge clk);
  endtask
  function automatic logic signed [VW-1:0] rnd();
    rnd = $signed($urandom);
  endfunction
  // Offers one sample at a random lag, waits for its result.
  task automatic smp(input logic [VW-1:0] v, input logic o);
    int i;
    @(posedge clk);
    {send, val, ovl} <= {1'b1, v, o};
    lag <= 4'($urandom_range(0, 3));
    range_prefix <= 3'($urandom_range(0, 5));
    @(posedge clk);
    send <= 1'b0;
    for (i = 0; i < 1000 && res_valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 1000) begin
      n_errors++;
      $display("ERROR res_valid expected 1 seen 0");
      wrap_up();
    end
    chk_v("autorange_value", v, ar_value);
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {resetn, reg_we, reg_re, send, ovl, n_errors, compares} = '0;
    {reg_addr, reg_wdata, val, lag, kv, range_prefix} = '0;
    void'($urandom(54830));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rd(`MPC_REG_SMCOUNT);
    chk_w("smcount", {25'h0, `MPC_SMN_RST}, rd_d);
    rd(`MPC_REG_STATUS);
    chk_w("status", 32'h0, rd_d);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40);
    chk_w("unmapped", 32'h0, rd_d);
    x1 = rnd();
    smp(x1, 1'b0);
    chk_v("pass_value", x1, res_value);
    $display("test reset_and_pass done");
    pulse(0);
    x2 = rnd();
    smp(x2, 1'b1);
    chk_v("ovl_value", x2, res_value);
    chk_v("ovl_flag", 1, ovl_f);
    x1 = rnd();
    smp(x1, 1'b0);
    chk_v("null_first", '0, res_value);
    x2 = rnd();
    smp(x2, 1'b0);
    chk_v("null_value", x2 - x1, res_value);
    chk_v("null_ind", 1, null_ind);
    pulse(0);
    chk_v("null_ind", 0, null_ind);
    smp(x2, 1'b0);
    chk_v("null_off", x2, res_value);
    $display("test null done");
    wr(`MPC_REG_SMCOUNT, 32'h3);
    wr(`MPC_REG_SMCOUNT, 32'h65);
    rd(`MPC_REG_SMCOUNT);
    chk_w("smcount", 32'h3, rd_d);
    pulse(1);
    for (k = 0; k < 6; k++) begin
      x1 = rnd();
      smp(x1, k == 2);
      if (k == 2) begin
        chk_v("sm_ovl", 1, ovl_f);
      end else begin
        hist.push_back(x1);
        if (hist.size() > 3) void'(hist.pop_front());
        e = '0;
        foreach (hist[j]) e += hist[j];
        e = e / hist.size();
        chk_v("sm_mean", e, res_value);
      end
    end
    chk_v("sm_ind", 1, sm_ind);
    repeat (9) @(posedge clk);
    chk_v("sm_ind", 1, sm_ind);
    pulse(6);
    x1 = rnd();
    smp(x1, 1'b0);
    chk_v("sm_flush", x1, res_value);
    pulse(4);
    chk_v("sm_ind", 0, sm_ind);
    smp(x2, 1'b0);
    chk_v("sm_off", x2, res_value);
    $display("test smoother done");
    wr(`MPC_REG_A_M, 32'h2);
    wr(`MPC_REG_A_E, 32'h0);
    wr(`MPC_REG_B_M, 32'h5);
    wr(`MPC_REG_B_E, {29'h0, `MPC_PFX_MILLI});
    wr(`MPC_REG_C_M, 32'h3);
    wr(`MPC_REG_C_E, 32'h0);
    pulse(2);
    chk_v("sc_ind", 1, sc_ind);
    for (k = -1; k < 2; k += 2) begin
      r = $urandom_range(1, 1048576);
      smp(96'sd500000000000 + 2 * k * r, 1'b0);
      chk_v("scaled", 3 * k * r, res_value);
      chk_v("sovf", 0, sovf);
      chk_v("prefix", `MPC_PFX_NANO, res_prefix);
    end
    x1 = 96'sd100000000000000000000000;
    smp(x1, 1'b0);
    chk_v("sovf", 1, sovf);
    wr(`MPC_REG_EDITSEL, 32'h3);
    pulse(3);
    rd(`MPC_REG_C_M);
    chk_w("capture", x1[31:0], rd_d);
    pulse(5);
    chk_v("sc_ind", 0, sc_ind);
    smp(x2, 1'b0);
    chk_v("sc_off", x2, res_value);
    $display("test scaling done");
    wrap_up();
  end
endmodule
`default_nettype wire
